// ==== rtl/sdrini_pkg.sv ====
// shared constants for the sdram command, mode and burst block
package sdrini_pkg;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_ACTIVE    = 4'h3;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_BURST_END = 4'h6;
    localparam logic [3:0] CMD_IDLE      = 4'hf;
    // operating_mode_register field positions, precharge-all address bit and array sizes
    localparam int BL_LO       = 0;
    localparam int BL_HI       = 2;
    localparam int ORDER_BIT   = 3;
    localparam int LAT_LO      = 4;
    localparam int LAT_HI      = 6;
    localparam int WBURST_BIT  = 9;
    localparam int PRE_ALL_BIT = 10;
    localparam int MODE_W      = 13;
    localparam int ROW_W       = 13;
    localparam int COL_MAX_W   = 12;
    localparam int BANKS       = 4;
    // burst length codes
    localparam logic [2:0] BL_ONE  = 3'h0;
    localparam logic [2:0] BL_TWO  = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT= 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    // read latency codes and the mode reset value
    localparam logic [2:0] LAT_TWO   = 3'h2;
    localparam logic [2:0] LAT_THREE = 3'h3;
    localparam logic [12:0] MODE_RESET = 13'h0000;
endpackage

// ==== rtl/sdrini_core.sv ====
// sdram command decode, mode register, bank rows and burst addressing
// ****************************************************************
// Notes on behaviour
// - all inputs are captured only on the rising clock edge
// - four banks of 8192 rows; 4096, 2048 or 1024 columns by width
// - read or write acts only on a bank with an activated row
// - activate takes bank from bank bits and row from address 0..12
// - column comes from address 0-9 plus 11,12 per data width
// - precharge all closes every bank, leaving all banks idle
// - mode load needs both bank bits zero; value kept until reloaded
// - data outputs are released once a mode load is taken
// - mode bits: length, order, latency, op mode, write burst
// - lengths 1,2,4,8 both orders; full row only sequential
// - burst length bounds locations touched per read or write
// - bursts wrap inside an aligned block of burst-length columns
// - full row bursts wrap at the row boundary
// - latency two or three; outputs drive from edge n+m-1
// - write burst bit set makes writes single location
// ****************************************************************
`timescale 1ns/100ps
module sdrini_core
    import sdrini_pkg::*;
#(
    parameter int DQ_BITS = 16
) (
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET,
    // command pins
    input  wire logic                  CKE,
    input  wire logic                  CS_N,
    input  wire logic                  RAS_N,
    input  wire logic                  CAS_N,
    input  wire logic                  WE_N,
    input  wire logic [1:0]            BA,
    input  wire logic [12:0]           ADDR,
    // array access strobe
    output logic                       ACC_VALID,
    output logic                       ACC_WRITE,
    output logic [1:0]                 ACC_BANK,
    output logic [12:0]                ACC_ROW,
    output logic [11:0]                ACC_COL,
    // data pin drive and status
    output logic                       DQ_OE,
    output logic [3:0]                 ROW_OPEN,
    output logic [12:0]                MODE_VALUE
);
    import sdrini_pkg::*;

    localparam int COL_BITS = (DQ_BITS == 16) ? 10 :
                              (DQ_BITS == 8) ? 11 : 12;
    localparam logic [11:0] COL_MASK = 12'((1 << COL_BITS) - 1);

    typedef struct packed {
        logic                    in_cke;
        logic [3:0]              in_cmd;
        logic [1:0]              in_ba;
        logic [12:0]             in_addr;
        logic [12:0]             mode;
        logic [3:0]              row_open;
        logic [3:0][12:0]        rows;
        logic                    bst_on;
        logic                    bst_wr;
        logic [1:0]              bst_bank;
        logic [11:0]             bst_start;
        logic [11:0]             bst_idx;
        logic [11:0]             bst_last;
        logic [1:0]              oe_dly;
        logic [12:0]             oe_left;
        logic                    acc_valid;
        logic                    acc_wr;
        logic [1:0]              acc_bank;
        logic [12:0]             acc_row;
        logic [11:0]             acc_col;
        logic                    dq_oe;
    } sdrini_state_t;

    sdrini_state_t q;
    sdrini_state_t next_q;

    function automatic logic [11:0] col_pick(input logic [12:0] a);
        logic [11:0] c;
        c = {a[12], a[11], a[9:0]};
        return c & COL_MASK;
    endfunction

    // length codes to last index; reserved codes act as one
    function automatic logic [11:0] last_of(input logic [2:0] code,
                                            input logic       seq);
        logic [11:0] l;
        l = 12'h000;
        case (code)
            BL_TWO:   l = 12'h001;
            BL_FOUR:  l = 12'h003;
            BL_EIGHT: l = 12'h007;
            BL_PAGE:  l = seq ? COL_MASK : 12'h000;
            default:  l = 12'h000;
        endcase
        return l;
    endfunction

    logic        cmd_ok;
    logic [11:0] beat_col;
    logic [11:0] wrap_sum;
    logic [11:0] new_last;

    always_comb begin
        next_q = q;
        // pins captured once per rising edge
        next_q.in_cke  = CKE;
        next_q.in_cmd  = {CS_N, RAS_N, CAS_N, WE_N};
        next_q.in_ba   = BA;
        next_q.in_addr = ADDR;
        next_q.acc_valid = 1'b0;
        next_q.acc_wr    = 1'b0;
        cmd_ok   = q.in_cke;
        wrap_sum = 12'(q.bst_start + q.bst_idx);
        // block bits kept, low bits wrap in the block
        // full row uses the column mask as block size
        if (q.mode[ORDER_BIT] && q.bst_last != COL_MASK) begin
            beat_col = (q.bst_start & ~q.bst_last) |
                       ((q.bst_start ^ q.bst_idx) & q.bst_last);
        end else begin
            beat_col = (q.bst_start & ~q.bst_last) |
                       (wrap_sum & q.bst_last);
        end
        new_last = last_of(q.mode[BL_HI:BL_LO], !q.mode[ORDER_BIT]);
        // write burst bit forces single-location writes
        if (q.in_cmd == CMD_WRITE && q.mode[WBURST_BIT]) begin
            new_last = 12'h000;
        end
        // one beat per cycle until the programmed length
        if (q.bst_on) begin
            next_q.acc_valid = 1'b1;
            next_q.acc_wr    = q.bst_wr;
            next_q.acc_bank  = q.bst_bank;
            next_q.acc_row   = q.rows[q.bst_bank];
            next_q.acc_col   = beat_col;
            if (q.bst_idx == q.bst_last) begin
                next_q.bst_on = 1'b0;
            end else begin
                next_q.bst_idx = 12'(q.bst_idx + 12'h001);
            end
        end
        if (cmd_ok) begin
            case (q.in_cmd)
                // bank and full row taken on activate
                CMD_ACTIVE: begin
                    next_q.row_open[q.in_ba] = 1'b1;
                    next_q.rows[q.in_ba]     = q.in_addr;
                end
                // accesses only to an activated bank
                CMD_READ, CMD_WRITE: begin
                    if (q.row_open[q.in_ba]) begin
                        next_q.bst_on    = 1'b1;
                        next_q.bst_wr    = (q.in_cmd == CMD_WRITE);
                        next_q.bst_bank  = q.in_ba;
                        next_q.bst_start = col_pick(q.in_addr);
                        next_q.bst_idx   = 12'h000;
                        next_q.bst_last  = new_last;
                        next_q.oe_left   = 13'h0000;
                        next_q.oe_dly    = 2'h0;
                        if (q.in_cmd == CMD_READ) begin
                            next_q.oe_left = 13'(new_last + 12'h002);
                            next_q.oe_dly  =
                                (q.mode[LAT_HI:LAT_LO] == LAT_THREE) ?
                                2'h1 : 2'h0;
                        end
                    end
                end
                // all-banks precharge leaves every bank idle
                CMD_PRECHARGE: begin
                    if (q.in_addr[PRE_ALL_BIT]) begin
                        next_q.row_open = 4'h0;
                    end else begin
                        next_q.row_open[q.in_ba] = 1'b0;
                    end
                end
                // only bank zero selection loads the mode
                CMD_LOAD_MODE: begin
                    if (q.in_ba == 2'h0) begin
                        next_q.mode = q.in_addr;
                    end
                    next_q.oe_left = 13'h0000;
                    next_q.bst_on  = 1'b0;
                end
                // full-row bursts are cut short here
                CMD_BURST_END: begin
                    next_q.bst_on  = 1'b0;
                    next_q.oe_left = 13'h0000;
                end
                default: begin
                end
            endcase
        end
        next_q.dq_oe = 1'b0;
        if (next_q.oe_left != 13'h0000) begin
            if (next_q.oe_dly != 2'h0) begin
                next_q.oe_dly = 2'(next_q.oe_dly - 2'h1);
            end else begin
                next_q.dq_oe   = 1'b1;
                next_q.oe_left = 13'(next_q.oe_left - 13'h0001);
            end
        end
    end

    // no power-on value is defined for the mode; reset gives a
    // simulation a clean start, the load command sets the real value
    always_ff @(posedge CLK) begin
        if (RESET) begin
            q          <= '0;
            q.in_cmd   <= CMD_IDLE;
            q.mode     <= MODE_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign ACC_VALID  = q.acc_valid;
    assign ACC_WRITE  = q.acc_wr;
    assign ACC_BANK   = q.acc_bank;
    assign ACC_ROW    = q.acc_row;
    assign ACC_COL    = q.acc_col;
    assign DQ_OE      = q.dq_oe;
    assign ROW_OPEN   = q.row_open;
    assign MODE_VALUE = q.mode;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_access_needs_row: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_READ && !q.row_open[q.in_ba] &&
        !q.bst_on |=> !q.acc_valid && !q.bst_on)
        else $error("access started on an idle bank");
    a_active_row_load: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_ACTIVE |=>
        q.row_open[$past(q.in_ba)] &&
        q.rows[$past(q.in_ba)] == $past(q.in_addr))
        else $error("activate did not capture bank and row");
    a_precharge_all: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_PRECHARGE && q.in_addr[PRE_ALL_BIT]
        |=> q.row_open == 4'h0)
        else $error("precharge all left a bank open");
    a_mode_load_kept: assert property (
        @(posedge CLK) disable iff (RESET)
        !(q.in_cke && q.in_cmd == CMD_LOAD_MODE && q.in_ba == 2'h0)
        |=> $stable(q.mode))
        else $error("mode changed without a load");
    a_load_releases_dq: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_LOAD_MODE |=> !q.dq_oe [*2])
        else $error("data outputs driven after mode load");
    a_single_write: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_WRITE && q.row_open[q.in_ba] &&
        q.mode[WBURST_BIT] |=> ##1 q.acc_valid ##1 !q.acc_valid)
        else $error("write burst not single location");
    a_beat_in_block: assert property (
        @(posedge CLK) disable iff (RESET)
        q.bst_on |=> (q.acc_col & ~$past(q.bst_last)) ==
        ($past(q.bst_start) & ~$past(q.bst_last)))
        else $error("burst left its block");
    a_latency_two: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_READ && q.row_open[q.in_ba] &&
        q.mode[LAT_HI:LAT_LO] == LAT_TWO |=> q.dq_oe ##1 q.acc_valid)
        else $error("latency two drive window misplaced");
    a_latency_three: assert property (
        @(posedge CLK) disable iff (RESET)
        q.in_cke && q.in_cmd == CMD_READ && q.row_open[q.in_ba] &&
        q.mode[LAT_HI:LAT_LO] == LAT_THREE |=> !q.dq_oe ##1 q.dq_oe)
        else $error("latency three drive window misplaced");
    a_col_in_range: assert property (
        @(posedge CLK) disable iff (RESET)
        q.acc_valid |-> (q.acc_col & ~COL_MASK) == 12'h000)
        else $error("column beyond row width");
endmodule

// ==== tb/sdrini_ctrl_model.sv ====
// controller model that drives the sdram command pins
`timescale 1ns/100ps
module sdrini_ctrl_model
    import sdrini_pkg::*;
#(
    parameter int WAIT_CYC = 12500,
    parameter int GAP      = 2
) (
    // clock
    input  wire logic        CLK,
    // command pins
    output logic             CKE,
    output logic             CS_N,
    output logic             RAS_N,
    output logic             CAS_N,
    output logic             WE_N,
    output logic [1:0]       BA,
    output logic [12:0]      ADDR
);
    initial begin
        CKE = 1'b0;
        {CS_N, RAS_N, CAS_N, WE_N} = CMD_IDLE;
        BA = 2'h0;
        ADDR = 13'h0000;
    end
    task automatic issue(input logic [3:0] c, input logic [1:0] b,
                         input logic [12:0] a);
        @(negedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} = c;
        BA = b;
        ADDR = a;
        @(negedge CLK);
        {CS_N, RAS_N, CAS_N, WE_N} = CMD_IDLE;
        // idle lines flip so nothing can lean on a stale value
        BA = ~b;
        ADDR = ~a;
        if (c == CMD_PRECHARGE || c == CMD_REFRESH || c == CMD_LOAD_MODE)
            repeat (GAP) @(negedge CLK);
    endtask
    // idle wait, clock enable raised midway
    task automatic init();
        repeat (WAIT_CYC / 2) @(negedge CLK);
        CKE = 1'b1;
        repeat (WAIT_CYC - WAIT_CYC / 2) @(negedge CLK);
        issue(CMD_PRECHARGE, 2'h0, 13'h0400);
        repeat (2) issue(CMD_REFRESH, 2'h0, 13'h0000);
    endtask
    task automatic load_mode(input logic [12:0] m);
        issue(CMD_PRECHARGE, 2'h0, 13'h0400);
        issue(CMD_LOAD_MODE, 2'h0, m & 13'h027f);
    endtask
endmodule

// ==== tb/sdram_init_and_mode_register_tb_top.sv ====
// self-checking bench for the sdram command, mode and burst block
`timescale 1ns/100ps
module sdram_init_and_mode_register_tb_top;
    import sdrini_pkg::*;
    logic        CLK, RESET;
    wire         CKE, CS_N, RAS_N, CAS_N, WE_N;
    wire  [1:0]  BA;
    wire  [12:0] ADDR;
    logic        ACC_VALID, ACC_WRITE, DQ_OE, last_wr;
    logic [1:0]  ACC_BANK, last_bank;
    logic [12:0] ACC_ROW, MODE_VALUE, last_row;
    logic [11:0] ACC_COL;
    logic [3:0]  ROW_OPEN;
    logic [11:0] beats[$];
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          dq_n, dq_first;
    sdrini_core #(.DQ_BITS(16)) dut_u (.CLK(CLK), .RESET(RESET),
        .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
        .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .ACC_VALID(ACC_VALID),
        .ACC_WRITE(ACC_WRITE), .ACC_BANK(ACC_BANK), .ACC_ROW(ACC_ROW),
        .ACC_COL(ACC_COL), .DQ_OE(DQ_OE), .ROW_OPEN(ROW_OPEN),
        .MODE_VALUE(MODE_VALUE));
    sdrini_ctrl_model #(.WAIT_CYC(12500), .GAP(2)) ctrl_u (.CLK(CLK),
        .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
        .WE_N(WE_N), .BA(BA), .ADDR(ADDR));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    always @(posedge CLK) cyc <= cyc + 1;
    // beats and read windows are logged where outputs are settled
    always @(negedge CLK) begin
        if (ACC_VALID === 1'b1) begin
            beats.push_back(ACC_COL);
            last_wr = ACC_WRITE;
            last_bank = ACC_BANK;
            last_row = ACC_ROW;
        end
        if (DQ_OE === 1'b1) begin
            if (dq_n == 0) dq_first = cyc;
            dq_n++;
        end
    end
    task automatic chk_val(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: count %0d want %0d", $time,
                     got, exp);
        end
    endtask
    function automatic logic [11:0] exp_col(input logic [11:0] s,
        input int len, input int k, input logic ilv);
        logic [11:0] m;
        m = 12'(len - 1);
        return (s & ~m) | ((ilv ? s ^ 12'(k) : s + 12'(k)) & m);
    endfunction
    task automatic setup(input logic [12:0] md);
        ctrl_u.load_mode(md);
        @(negedge CLK);
        chk_val(MODE_VALUE, md);
        chk_val({9'h0, ROW_OPEN}, 13'h0000);
        ctrl_u.issue(CMD_ACTIVE, 2'h1, 13'h1005);
        @(negedge CLK);
        chk_val({9'h0, ROW_OPEN}, 13'h0002);
        beats.delete();
        dq_n = 0;
    endtask
    task automatic run(input logic [3:0] c, input logic [11:0] s,
        input int len, input logic ilv, input int m, input int nb);
        int t;
        ctrl_u.issue(c, 2'h1, {1'b0, s});
        t = cyc;
        repeat (len + 8) @(negedge CLK);
        chk_cnt(beats.size(), nb);
        foreach (beats[k])
            chk_val({1'b0, beats[k]},
                    {1'b0, exp_col(s, len, k, ilv)});
        chk_val({11'h0, last_bank}, 13'h0001);
        chk_val(last_row, 13'h1005);
        chk_val({12'h0, last_wr}, {12'h0, c == CMD_WRITE});
        if (c == CMD_READ) begin
            chk_cnt(dq_first - t, m - 1);
            chk_cnt(dq_n, len + 1);
        end else
            chk_cnt(dq_n, 0);
    endtask
    task automatic t_init();
        chk_val(MODE_VALUE, MODE_RESET);
        chk_val({5'h0, ROW_OPEN, ACC_VALID, DQ_OE, 2'h0}, 13'h0000);
        ctrl_u.init();
        ctrl_u.issue(CMD_LOAD_MODE, 2'h1, 13'h0022);
        @(negedge CLK);
        chk_val(MODE_VALUE, MODE_RESET);
        setup(13'h0022);
        ctrl_u.issue(CMD_READ, 2'h2, 13'h0005);
        repeat (8) @(negedge CLK);
        chk_cnt(beats.size() + dq_n, 0);
        $display("test init done");
    endtask
    task automatic t_modes();
        logic [12:0] md [7] = '{13'h0022, 13'h0030, 13'h0021, 13'h002b,
                                13'h0033, 13'h0022, 13'h0222};
        int          nb [7] = '{4, 1, 2, 8, 8, 4, 1};
        for (int i = 0; i < 7; i++) begin
            setup(md[i]);
            run(i > 4 ? CMD_WRITE : CMD_READ, 12'h3fd, 1 << md[i][2:0],
                md[i][3], int'(md[i][6:4]), nb[i]);
        end
        $display("test modes done");
    endtask
    task automatic t_full_row();
        setup(13'h0027);
        ctrl_u.issue(CMD_READ, 2'h1, 13'h03fe);
        repeat (2) @(negedge CLK);
        ctrl_u.issue(CMD_BURST_END, 2'h0, 13'h0000);
        repeat (8) @(negedge CLK);
        // terminate lands one beat after it is captured: four beats
        chk_cnt(beats.size(), 4);
        chk_cnt(dq_n, 4);
        // x16 rows hold 1024 columns, so the burst wraps past 3ff to 0
        for (int k = 0; k < 4; k++)
            chk_val({1'b0, beats[k]},
                    {1'b0, (12'h3fe + 12'(k)) & 12'h3ff});
        // single-bank precharge must leave other banks alone
        ctrl_u.issue(CMD_PRECHARGE, 2'h0, 13'h0000);
        @(negedge CLK);
        chk_val({9'h0, ROW_OPEN}, 13'h0002);
        ctrl_u.issue(CMD_PRECHARGE, 2'h1, 13'h0000);
        @(negedge CLK);
        chk_val({9'h0, ROW_OPEN}, 13'h0000);
        $display("test full row done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLK);
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog ran out", $time);
        give_verdict();
    end
    initial begin
        RESET = 1'b1;
        dq_n = 0;
        repeat (16) @(posedge CLK);
        @(negedge CLK);
        RESET = 1'b0;
        @(negedge CLK);
        t_init();
        t_modes();
        t_full_row();
        give_verdict();
    end
endmodule
